// [hdl/ifls_pkg.sv]
// Package of offsets, field positions and reset values for the interrupt flag and level status block
// Overview of operation
// [RQ1] Top level bit reads 1 when the CPU level exceeds 7, else 0
// [RQ2] CPU level is top bit above the three low status word bits 7 to 5
// [RQ3] Control register bit 2 always reads 1
// [RQ4] Control bits 15 to 4 and 1 to 0 read 0; writes ignored
// [RQ5] Each flag reads 1 after a request, resets to 0, software readable and writable
// [RQ6] First flag register high byte holds UART2, external 2, timers, compares, DMA2
// [RQ7] First flag register low byte holds capture 6 and 5, bit 5 zero, others
// [RQ8] Second flag register holds fifteen sources with bit 4 unimplemented
// [RQ9] Flags stay set until written 0; a same-cycle event beats the clear
package ifls_pkg;
    localparam logic [3:0] OFS_CPU_CONTROL = 4'h0;
    localparam logic [3:0] OFS_FLAGS_A = 4'h2;
    localparam logic [3:0] OFS_FLAGS_B = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK_A = 4'h6;
    localparam logic [3:0] OFS_IRQ_MASK_B = 4'h8;
    localparam logic [3:0] OFS_STATUS_WORD = 4'hA;
    localparam int LEVEL_TOP_POS = 3;
    localparam int RESERVED_ONE_POS = 2;
    localparam int LOW_BITS_HI = 7;
    localparam int LOW_BITS_LO = 5;
    localparam logic [3:0] LEVEL_THRESHOLD = 4'h7;
    localparam logic [15:0] FLAGS_A_IMPL = 16'hFFDF;
    localparam logic [15:0] FLAGS_B_IMPL = 16'hFFEF;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [2:0] LOW_BITS_RESET = 3'h0;
endpackage

// [hdl/ifls_flag_if.sv]
// Interface carrying one flag register's events and software access
`timescale 1ns/10ps
`default_nettype none
interface ifls_flag_if;
    logic [15:0] events;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] flags;
    modport bank (input events, input wr, input wdata, output flags);
    modport ctl (output events, output wr, output wdata, input flags);
endinterface
`default_nettype wire

// [hdl/ifls_flag_bank.sv]
// One sixteen-bit bank of sticky interrupt flags
`timescale 1ns/10ps
`default_nettype none
module ifls_flag_bank #(
    parameter logic [15:0] IMPL = 16'hFFFF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Flag access
    ifls_flag_if.bank fb
);
    logic [15:0] flags_r;
    logic [15:0] flags_nxt;

    always_comb begin
        flags_nxt = fb.wr ? fb.wdata : flags_r; // RQ5
        flags_nxt = (flags_nxt | fb.events) & IMPL; // RQ9
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= ifls_pkg::FLAGS_RESET; // RQ5
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign fb.flags = flags_r;

    a_event_wins_clear: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
        (fb.events[0] && IMPL[0]) |=> flags_r[0])
        else $error("event lost against clear");
    a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
        (flags_r[1] && !fb.wr) |=> flags_r[1])
        else $error("flag dropped without write");
endmodule
`default_nettype wire

// [hdl/ifls_top.sv]
// Interrupt flag and CPU level status block with register port and interrupt output
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ifls_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    // Level set by the CPU core
    input wire logic set_level_top,
    input wire logic clr_level_top,
    // Source events, first bank
    input wire logic uart2_tx_flag,
    input wire logic uart2_rx_flag,
    input wire logic ext_in2_flag,
    input wire logic timer5_flag,
    input wire logic timer4_flag,
    input wire logic out_cmp4_flag,
    input wire logic out_cmp3_flag,
    input wire logic dma_ch2_flag,
    input wire logic capcmp6_flag,
    input wire logic capcmp5_flag,
    input wire logic ext_in1_flag,
    input wire logic pin_change_flag,
    input wire logic comparator_flag,
    input wire logic i2c1_master_flag,
    input wire logic i2c1_slave_flag,
    // Source events, second bank
    input wire logic multi_capcmp1_flag,
    input wire logic rtc_flag,
    input wire logic dma_ch5_flag,
    input wire logic spi3_rx_flag,
    input wire logic spi2_rx_flag,
    input wire logic spi1_rx_flag,
    input wire logic spi4_rx_flag,
    input wire logic key_store_done_flag,
    input wire logic crypto_done_flag,
    input wire logic ext_in4_flag,
    input wire logic ext_in3_flag,
    input wire logic capcmp7_timer_flag,
    input wire logic i2c2_master_flag,
    input wire logic i2c2_slave_flag,
    input wire logic capcmp6_timer_flag,
    // Status outputs
    output logic [3:0] cpu_level,
    output logic irq
);
    logic cpu_level_top_bit_r;
    logic [2:0] cpu_level_low_bits_r;
    logic [15:0] mask_a_r;
    logic [15:0] mask_b_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [15:0] cpu_control;

    ifls_flag_if fa ();
    ifls_flag_if fbk ();

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    // Event mapping, first bank
    assign fa.events = {uart2_tx_flag, uart2_rx_flag, ext_in2_flag, timer5_flag,
        timer4_flag, out_cmp4_flag, out_cmp3_flag, dma_ch2_flag,
        capcmp6_flag, capcmp5_flag, 1'b0, ext_in1_flag,
        pin_change_flag, comparator_flag, i2c1_master_flag, i2c1_slave_flag}; // RQ6 RQ7
    assign fa.wr = wr_en && hit(addr, ifls_pkg::OFS_FLAGS_A);
    assign fa.wdata = wdata;

    // Event mapping, second bank
    assign fbk.events = {multi_capcmp1_flag, rtc_flag, dma_ch5_flag, spi3_rx_flag,
        spi2_rx_flag, spi1_rx_flag, spi4_rx_flag, key_store_done_flag,
        crypto_done_flag, ext_in4_flag, ext_in3_flag, 1'b0,
        capcmp7_timer_flag, i2c2_master_flag, i2c2_slave_flag, capcmp6_timer_flag}; // RQ8
    assign fbk.wr = wr_en && hit(addr, ifls_pkg::OFS_FLAGS_B);
    assign fbk.wdata = wdata;

    ifls_flag_bank #(.IMPL(ifls_pkg::FLAGS_A_IMPL)) u_bank_a (
        .clk(clk),
        .rst_n(rst_n),
        .fb(fa)
    );

    ifls_flag_bank #(.IMPL(ifls_pkg::FLAGS_B_IMPL)) u_bank_b (
        .clk(clk),
        .rst_n(rst_n),
        .fb(fbk)
    );

    // Each source lands on its own flag position
    a_uart2_tx_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        uart2_tx_flag |=> fa.flags[15])
        else $error("uart2 transmit flag misplaced");
    a_uart2_rx_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        uart2_rx_flag |=> fa.flags[14])
        else $error("uart2 receive flag misplaced");
    a_ext_in2_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        ext_in2_flag |=> fa.flags[13])
        else $error("external 2 flag misplaced");
    a_timer5_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        timer5_flag |=> fa.flags[12])
        else $error("timer 5 flag misplaced");
    a_timer4_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        timer4_flag |=> fa.flags[11])
        else $error("timer 4 flag misplaced");
    a_out_cmp4_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        out_cmp4_flag |=> fa.flags[10])
        else $error("compare 4 flag misplaced");
    a_out_cmp3_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        out_cmp3_flag |=> fa.flags[9])
        else $error("compare 3 flag misplaced");
    a_dma_ch2_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        dma_ch2_flag |=> fa.flags[8])
        else $error("dma 2 flag misplaced");
    a_capcmp6_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        capcmp6_flag |=> fa.flags[7])
        else $error("capture 6 flag misplaced");
    a_capcmp5_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        capcmp5_flag |=> fa.flags[6])
        else $error("capture 5 flag misplaced");
    a_ext_in1_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        ext_in1_flag |=> fa.flags[4])
        else $error("external 1 flag misplaced");
    a_pin_change_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        pin_change_flag |=> fa.flags[3])
        else $error("pin change flag misplaced");
    a_comparator_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        comparator_flag |=> fa.flags[2])
        else $error("comparator flag misplaced");
    a_i2c1_master_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        i2c1_master_flag |=> fa.flags[1])
        else $error("i2c1 master flag misplaced");
    a_i2c1_slave_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        i2c1_slave_flag |=> fa.flags[0])
        else $error("i2c1 slave flag misplaced");
    a_multi_capcmp_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        multi_capcmp1_flag |=> fbk.flags[15])
        else $error("multi capture flag misplaced");
    a_rtc_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        rtc_flag |=> fbk.flags[14])
        else $error("rtc flag misplaced");
    a_dma_ch5_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        dma_ch5_flag |=> fbk.flags[13])
        else $error("dma 5 flag misplaced");
    a_spi3_rx_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        spi3_rx_flag |=> fbk.flags[12])
        else $error("spi3 receive flag misplaced");
    a_spi2_rx_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        spi2_rx_flag |=> fbk.flags[11])
        else $error("spi2 receive flag misplaced");
    a_spi1_rx_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        spi1_rx_flag |=> fbk.flags[10])
        else $error("spi1 receive flag misplaced");
    a_spi4_rx_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        spi4_rx_flag |=> fbk.flags[9])
        else $error("spi4 receive flag misplaced");
    a_key_store_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        key_store_done_flag |=> fbk.flags[8])
        else $error("key store flag misplaced");
    a_crypto_done_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        crypto_done_flag |=> fbk.flags[7])
        else $error("crypto done flag misplaced");
    a_ext_in4_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        ext_in4_flag |=> fbk.flags[6])
        else $error("external 4 flag misplaced");
    a_ext_in3_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        ext_in3_flag |=> fbk.flags[5])
        else $error("external 3 flag misplaced");
    a_capcmp7_timer_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        capcmp7_timer_flag |=> fbk.flags[3])
        else $error("capture timer 7 flag misplaced");
    a_i2c2_master_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        i2c2_master_flag |=> fbk.flags[2])
        else $error("i2c2 master flag misplaced");
    a_i2c2_slave_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        i2c2_slave_flag |=> fbk.flags[1])
        else $error("i2c2 slave flag misplaced");
    a_capcmp6_timer_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        capcmp6_timer_flag |=> fbk.flags[0])
        else $error("capture timer 6 flag misplaced");

    // Low level bits of the status word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_level_low_bits_r <= ifls_pkg::LOW_BITS_RESET;
        end else if (wr_en && hit(addr, ifls_pkg::OFS_STATUS_WORD)) begin
            cpu_level_low_bits_r <= wdata[ifls_pkg::LOW_BITS_HI:ifls_pkg::LOW_BITS_LO]; // RQ2
        end
    end

    // Top level bit, set by the core, clearable by software writing 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_level_top_bit_r <= 1'b0;
        end else if (set_level_top) begin
            cpu_level_top_bit_r <= 1'b1; // RQ1
        end else if (clr_level_top) begin
            cpu_level_top_bit_r <= 1'b0; // RQ1
        end else if (wr_en && hit(addr, ifls_pkg::OFS_CPU_CONTROL) && !wdata[ifls_pkg::LEVEL_TOP_POS]) begin
            cpu_level_top_bit_r <= 1'b0; // RQ1
        end
    end

    assign cpu_level = {cpu_level_top_bit_r, cpu_level_low_bits_r}; // RQ2

    // Level bit behaviour
    a_level_set: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
        set_level_top |=> cpu_level[3])
        else $error("top level bit not set");
    a_level_clear: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
        (clr_level_top && !set_level_top) |=> !cpu_level[3])
        else $error("top level bit not cleared");
    a_level_soft_clear: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
        (wr_en && addr == ifls_pkg::OFS_CPU_CONTROL && !wdata[3] && !set_level_top) |=> !cpu_level[3])
        else $error("top level bit not cleared by write");
    a_level_top_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
        (!set_level_top && !clr_level_top && !(wr_en && addr == ifls_pkg::OFS_CPU_CONTROL && !wdata[3]))
        |=> $stable(cpu_level[3]))
        else $error("top level bit moved");
    a_low_bits_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
        !(wr_en && addr == ifls_pkg::OFS_STATUS_WORD) |=> $stable(cpu_level[2:0]))
        else $error("low level bits moved");

    // Control register image
    always_comb begin
        cpu_control = 16'h0000; // RQ4
        cpu_control[ifls_pkg::LEVEL_TOP_POS] = cpu_level_top_bit_r; // RQ1
        cpu_control[ifls_pkg::RESERVED_ONE_POS] = 1'b1; // RQ3
    end

    // Interrupt masks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_a_r <= ifls_pkg::MASK_RESET;
            mask_b_r <= ifls_pkg::MASK_RESET;
        end else begin
            if (wr_en && hit(addr, ifls_pkg::OFS_IRQ_MASK_A)) begin
                mask_a_r <= wdata & ifls_pkg::FLAGS_A_IMPL;
            end
            if (wr_en && hit(addr, ifls_pkg::OFS_IRQ_MASK_B)) begin
                mask_b_r <= wdata & ifls_pkg::FLAGS_B_IMPL;
            end
        end
    end

    assign irq = |(fa.flags & mask_a_r) || |(fbk.flags & mask_b_r);

    // Read path
    always_comb begin
        rdata_nxt = 16'h0000;
        if (rd_en) begin
            unique case (addr)
                ifls_pkg::OFS_CPU_CONTROL: rdata_nxt = cpu_control;
                ifls_pkg::OFS_FLAGS_A: rdata_nxt = fa.flags; // RQ5
                ifls_pkg::OFS_FLAGS_B: rdata_nxt = fbk.flags; // RQ5
                ifls_pkg::OFS_IRQ_MASK_A: rdata_nxt = mask_a_r;
                ifls_pkg::OFS_IRQ_MASK_B: rdata_nxt = mask_b_r;
                ifls_pkg::OFS_STATUS_WORD: rdata_nxt = {8'h00, cpu_level_low_bits_r, 5'h00};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

    a_level_top_read: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
        (rd_en && addr == ifls_pkg::OFS_CPU_CONTROL)
        |=> (rdata[3] == ($past(cpu_level) > ifls_pkg::LEVEL_THRESHOLD)))
        else $error("top level bit does not match level");
    a_level_concat: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
        (wr_en && addr == ifls_pkg::OFS_STATUS_WORD) |=> (cpu_level[2:0] == $past(wdata[7:5])))
        else $error("low level bits not taken");
    a_reserved_one: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
        (rd_en && addr == ifls_pkg::OFS_CPU_CONTROL) |=> rdata[2])
        else $error("reserved bit not one");
    a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
        (rd_en && addr == ifls_pkg::OFS_CPU_CONTROL) |=> (rdata[15:4] == 12'h000 && rdata[1:0] == 2'h0))
        else $error("unimplemented control bits not zero");
    a_control_image: assert property (@(posedge clk) disable iff (!rst_n) // RQ3 RQ4
        (rd_en && addr == ifls_pkg::OFS_CPU_CONTROL) |=> (rdata == {12'h000, $past(cpu_level[3]), 3'h4}))
        else $error("control register image wrong");
    a_flag_set_read: assert property (@(posedge clk) disable iff (!rst_n) // RQ5 RQ6
        (timer5_flag ##1 !fa.wr ##1 (rd_en && addr == ifls_pkg::OFS_FLAGS_A)) |=> rdata[12])
        else $error("timer flag not at bit 12");
    a_flags_a_read: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
        (rd_en && addr == ifls_pkg::OFS_FLAGS_A) |=> (rdata == $past(fa.flags)))
        else $error("first bank read wrong");
    a_flags_b_read: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
        (rd_en && addr == ifls_pkg::OFS_FLAGS_B) |=> (rdata == $past(fbk.flags)))
        else $error("second bank read wrong");
    a_low_bits_read: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
        (rd_en && addr == ifls_pkg::OFS_STATUS_WORD) |=> (rdata[7:5] == $past(cpu_level[2:0])))
        else $error("low level bits read wrong");
    a_uart2_tx_write: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
        (fa.wr && wdata[15]) |=> fa.flags[15])
        else $error("first bank write not taken");
    a_i2c2_slave_write: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
        (fbk.wr && wdata[1]) |=> fbk.flags[1])
        else $error("second bank write not taken");
    a_key_store_write: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
        (fbk.wr && wdata[8]) |=> fbk.flags[8])
        else $error("key store flag write not taken");
    a_bank_a_gap: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        (rd_en && addr == ifls_pkg::OFS_FLAGS_A) |=> !rdata[5])
        else $error("first bank bit 5 not zero");
    a_bank_b_gap: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        (rd_en && addr == ifls_pkg::OFS_FLAGS_B) |=> !rdata[4])
        else $error("second bank bit 4 not zero");
    a_bank_a_hole: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
        !fa.flags[5])
        else $error("first bank bit 5 stored");
    a_bank_b_hole: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
        !fbk.flags[4])
        else $error("second bank bit 4 stored");
    a_timer5_clear: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
        (fa.wr && !wdata[12] && !timer5_flag) |=> !fa.flags[12])
        else $error("timer flag not cleared");
    a_rtc_clear: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
        (fbk.wr && !wdata[14] && !rtc_flag) |=> !fbk.flags[14])
        else $error("rtc flag not cleared");
    a_timer5_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
        (fa.flags[12] && !fa.wr) |=> fa.flags[12])
        else $error("timer flag dropped without write");
    a_rtc_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
        (fbk.flags[14] && !fbk.wr) |=> fbk.flags[14])
        else $error("rtc flag dropped without write");
    a_rtc_wins: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
        (rtc_flag && fbk.wr && !wdata[14]) |=> fbk.flags[14])
        else $error("rtc event lost against clear");
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench for the interrupt flag and CPU level status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, e); end end
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic set_top = 1'b0;
    logic clr_top = 1'b0;
    logic [15:0] ev_a = 16'h0000;
    logic [15:0] ev_b = 16'h0000;
    logic [15:0] rdata;
    logic [3:0] cpu_level;
    logic irq;
    int error_cnt = 0;
    int tests_run = 0;
    ifls_top dut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .set_level_top(set_top), .clr_level_top(clr_top),
        .uart2_tx_flag(ev_a[15]), .uart2_rx_flag(ev_a[14]), .ext_in2_flag(ev_a[13]), .timer5_flag(ev_a[12]),
        .timer4_flag(ev_a[11]), .out_cmp4_flag(ev_a[10]), .out_cmp3_flag(ev_a[9]), .dma_ch2_flag(ev_a[8]),
        .capcmp6_flag(ev_a[7]), .capcmp5_flag(ev_a[6]), .ext_in1_flag(ev_a[4]), .pin_change_flag(ev_a[3]),
        .comparator_flag(ev_a[2]), .i2c1_master_flag(ev_a[1]), .i2c1_slave_flag(ev_a[0]),
        .multi_capcmp1_flag(ev_b[15]), .rtc_flag(ev_b[14]), .dma_ch5_flag(ev_b[13]), .spi3_rx_flag(ev_b[12]),
        .spi2_rx_flag(ev_b[11]), .spi1_rx_flag(ev_b[10]), .spi4_rx_flag(ev_b[9]), .key_store_done_flag(ev_b[8]),
        .crypto_done_flag(ev_b[7]), .ext_in4_flag(ev_b[6]), .ext_in3_flag(ev_b[5]), .capcmp7_timer_flag(ev_b[3]),
        .i2c2_master_flag(ev_b[2]), .i2c2_slave_flag(ev_b[1]), .capcmp6_timer_flag(ev_b[0]),
        .cpu_level(cpu_level), .irq(irq)
    );
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic end_of_test;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic level(input logic s, input logic c);
        @(posedge clk);
        set_top <= s;
        clr_top <= c;
        @(posedge clk);
        set_top <= 1'b0;
        clr_top <= 1'b0;
    endtask
    task automatic clash(input logic [3:0] a, input logic [15:0] ea, input logic [15:0] eb);
        @(posedge clk);
        ev_a <= ea;
        ev_b <= eb;
        addr <= a;
        wdata <= 16'h0000;
        wr_en <= 1'b1;
        @(posedge clk);
        ev_a <= 16'h0000;
        ev_b <= 16'h0000;
        wr_en <= 1'b0;
    endtask
    initial begin
        #(40 * 3000);
        error_cnt++;
        end_of_test();
    end
    initial begin
        logic [3:0] ofs;
        logic [15:0] imp;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        `CHK(irq, 1'b0)
        `CHK(cpu_level, 4'h0)
        rd(ifls_pkg::OFS_CPU_CONTROL, 16'h0004);
        rd(ifls_pkg::OFS_FLAGS_A, 16'h0000);
        rd(ifls_pkg::OFS_FLAGS_B, 16'h0000);
        wr(ifls_pkg::OFS_CPU_CONTROL, 16'hFFFF);
        rd(ifls_pkg::OFS_CPU_CONTROL, 16'h0004);
        level(1'b1, 1'b1);
        rd(ifls_pkg::OFS_CPU_CONTROL, 16'h000C);
        wr(ifls_pkg::OFS_STATUS_WORD, 16'hFFFF);
        rd(ifls_pkg::OFS_STATUS_WORD, 16'h00E0);
        `CHK(cpu_level, 4'hF)
        level(1'b0, 1'b1);
        rd(ifls_pkg::OFS_CPU_CONTROL, 16'h0004);
        `CHK(cpu_level, 4'h7)
        level(1'b1, 1'b0);
        wr(ifls_pkg::OFS_CPU_CONTROL, 16'h0000);
        rd(ifls_pkg::OFS_CPU_CONTROL, 16'h0004);
        // Each source sets only its own flag; masks are still clear
        for (int b = 0; b < 2; b++) begin
            ofs = (b == 1) ? ifls_pkg::OFS_FLAGS_B : ifls_pkg::OFS_FLAGS_A;
            imp = (b == 1) ? 16'hFFEF : 16'hFFDF;
            for (int i = 0; i < 16; i++) begin
                @(posedge clk);
                if (b == 1) ev_b[i] <= 1'b1;
                else ev_a[i] <= 1'b1;
                @(posedge clk);
                ev_a <= 16'h0000;
                ev_b <= 16'h0000;
                rd(ofs, (16'h0001 << i) & imp);
                `CHK(irq, 1'b0)
                wr(ofs, 16'h0000);
                rd(ofs, 16'h0000);
            end
        end
        wr(ifls_pkg::OFS_FLAGS_A, 16'hFFFF);
        rd(ifls_pkg::OFS_FLAGS_A, 16'hFFDF);
        wr(ifls_pkg::OFS_FLAGS_B, 16'hFFFF);
        rd(ifls_pkg::OFS_FLAGS_B, 16'hFFEF);
        wr(ifls_pkg::OFS_IRQ_MASK_A, 16'h1000);
        rd(ifls_pkg::OFS_IRQ_MASK_A, 16'h1000);
        `CHK(irq, 1'b1)
        wr(ifls_pkg::OFS_FLAGS_A, 16'h0000);
        rd(ifls_pkg::OFS_FLAGS_A, 16'h0000);
        `CHK(irq, 1'b0)
        wr(ifls_pkg::OFS_IRQ_MASK_B, 16'h0010);
        rd(ifls_pkg::OFS_IRQ_MASK_B, 16'h0000);
        wr(ifls_pkg::OFS_IRQ_MASK_B, 16'h8000);
        rd(ifls_pkg::OFS_FLAGS_B, 16'hFFEF);
        `CHK(irq, 1'b1)
        wr(ifls_pkg::OFS_FLAGS_B, 16'h0000);
        rd(ifls_pkg::OFS_FLAGS_B, 16'h0000);
        `CHK(irq, 1'b0)
        // Event and clear in the same cycle: the event must survive
        clash(ifls_pkg::OFS_FLAGS_A, 16'h1000, 16'h0000);
        rd(ifls_pkg::OFS_FLAGS_A, 16'h1000);
        `CHK(irq, 1'b1)
        clash(ifls_pkg::OFS_FLAGS_B, 16'h0000, 16'h4000);
        rd(ifls_pkg::OFS_FLAGS_B, 16'h4000);
        wr(4'hE, 16'hFFFF);
        rd(4'hE, 16'h0000);
        end_of_test();
    end
endmodule
`default_nettype wire
